// [inc/hcl_pkg.sv]
// Constants, types and settings layout of the hub configuration loader
package hcl_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int I2C_QUARTER_NS = 2500;
  localparam int I2C_QUARTER_CYC = (I2C_QUARTER_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   I2C_QUARTER_NS / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYC = 3;
  localparam int VBUS_DROP_LIMIT_S = 10;

  // ==========================================================================
  // Two-wire memory access
  // ==========================================================================
  localparam logic [7:0] EE_CTRL_WRITE = 8'ha0;
  localparam logic [7:0] EE_CTRL_READ = 8'ha1;
  localparam logic [7:0] EE_FIRST_ADDR = 8'h00;
  localparam logic [7:0] EE_LAST_ADDR = 8'hff;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [1:0] TX_CTRL_WR = 2'h0;
  localparam logic [1:0] TX_WORD_ADDR = 2'h1;
  localparam logic [1:0] TX_CTRL_RD = 2'h2;
  localparam logic [1:0] QTR_SAMPLE = 2'h1;
  localparam logic [1:0] QTR_LAST = 2'h3;

  // ==========================================================================
  // SMBus slave and register map
  // ==========================================================================
  localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;
  localparam logic [7:0] REG_CFG_BYTE1 = 8'h06;
  localparam logic [7:0] REG_NONREM = 8'h09;
  localparam logic [7:0] REG_STATUS_CMD = 8'hff;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int CFG1_SELF_PWR_BIT = 7;
  localparam int STATUS_ATTACH_BIT = 0;
  localparam logic [7:0] ROM_CFG_BYTE1 = 8'h9b;
  localparam logic [7:0] ROM_NONREM = 8'h00;

  // ==========================================================================
  // Transaction translator buffering
  // ==========================================================================
  localparam logic [10:0] TT_PERIODIC_BYTES = 11'h5e8;
  localparam logic [8:0] TT_NONPER_BYTES = 9'h110;
  localparam logic [2:0] TT_NONPER_BUFS = 3'h4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    HCL_MODE_SELF = 2'h0,
    HCL_MODE_SMBUS = 2'h1,
    HCL_MODE_BUS = 2'h2,
    HCL_MODE_EEPROM = 2'h3
  } hcl_mode_t;

  typedef enum logic [8:0] {
    HCL_ST_IDLE = 9'h001,
    HCL_ST_START = 9'h002,
    HCL_ST_TX = 9'h004,
    HCL_ST_TACK = 9'h008,
    HCL_ST_RX = 9'h010,
    HCL_ST_RACK = 9'h020,
    HCL_ST_STOP = 9'h040,
    HCL_ST_DONE = 9'h080,
    HCL_ST_WAIT = 9'h100
  } hcl_state_t;

  typedef struct packed {
    logic [3:0] nonrem;
    logic susp_low;
    logic self_pwr;
  } hcl_settings_t;

  typedef struct packed {
    logic [10:0] periodic;
    logic [8:0] nonper;
    logic [2:0] nonper_bufs;
  } hcl_tt_cfg_t;

endpackage

// [sim/hcl_eeprom_model.sv]
// Behavioural two-wire configuration memory facing the loader
`timescale 1ns/100ps
module hcl_eeprom_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic present_in,
  output logic sda_oe_out,
  output int rx_bytes_out
);
  logic [7:0] mem [256];
  logic [7:0] sh = 8'h00, ptr = 8'h00;
  logic rd_mode = 1'b0, rd_next = 1'b0, got_ctrl = 1'b0;
  int bitn = 9;
  initial begin
    sda_oe_out = 1'b0;
    rx_bytes_out = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end
  // Start condition restarts byte framing
  always @(negedge sda_in) begin
    if (scl_in) begin
      bitn = -1;
      got_ctrl = 1'b0;
      rd_mode = 1'b0;
      rd_next = 1'b0;
    end
  end
  always @(posedge scl_in) begin
    if (bitn < 8 && !rd_mode) begin
      sh = {sh[6:0], sda_in};
    end else if (bitn == 8 && rd_mode) begin
      ptr = ptr + 8'h01;
      rd_mode = !sda_in;
    end
  end
  // bytes served from the pointer upward
  always @(negedge scl_in) begin
    bitn = bitn + 1;
    if (bitn == 8 && !rd_mode) begin
      rx_bytes_out++;
      if (got_ctrl) begin
        ptr = sh;
      end else begin
        rd_next = sh[0];
      end
      got_ctrl = 1'b1;
      sda_oe_out = present_in;
    end else if (bitn == 8) begin
      sda_oe_out = 1'b0;
    end else if (bitn == 9) begin
      bitn = 0;
      rd_mode = rd_mode | rd_next;
      rd_next = 1'b0;
      sda_oe_out = present_in & rd_mode & ~mem[ptr][7];
    end else if (rd_mode && bitn > 0) begin
      sda_oe_out = present_in & ~mem[ptr][3'(7 - bitn)];
    end
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the hub configuration loader
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, st_lo = 1'b0, st_hi = 1'b0;
  logic vbus = 1'b1, act = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, present = 1'b1;
  logic sda_w, sda_o, mdl_oe, scl, dut_oe, sen, done, pull, susp, selfp;
  logic [3:0] preq = 4'h0, nrem, ppen;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, e9;
  logic [6:0] saddr;
  logic [7:0] expq [$];
  hcl_pkg::hcl_tt_cfg_t tt;
  int miscompares = 0, total_checks = 0, seed = 32'h61be, rx_bytes;
  assign sda_w = ~(dut_oe | mdl_oe);
  hcl_config_loader #(.QUARTER_CYC(4)) dut (.clk_sys_in(clk), .resetn_in(rstn),
    .config_select_lo_in(sel_lo), .config_select_hi_in(sel_hi),
    .nonremovable_strap_lo_in(st_lo), .nonremovable_strap_hi_in(st_hi),
    .upstream_vbus_detect_in(vbus), .hub_active_in(act), .port_power_req_in(preq),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .eeprom_scl_out(scl), .eeprom_sda_in(sda_w), .eeprom_sda_out(sda_o),
    .eeprom_sda_oe_out(dut_oe), .smbus_slave_en_out(sen), .smbus_slave_addr_out(saddr),
    .config_done_out(done), .upstream_pullup_en_out(pull), .suspend_indicator_out(susp),
    .self_powered_out(selfp), .nonremovable_ports_out(nrem), .port_power_en_out(ppen),
    .tt_cfg_out(tt));
  hcl_eeprom_model mdl (.scl_in(scl), .sda_in(sda_w), .present_in(present),
    .sda_oe_out(mdl_oe), .rx_bytes_out(rx_bytes));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic [1:0] sel, input logic [1:0] st);
    @(posedge clk);
    rstn <= 1'b0;
    {sel_hi, sel_lo, st_hi, st_lo} <= {sel, st};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    {sel_hi, sel_lo, st_hi, st_lo} <= ~{sel, st};
  endtask
  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 1'b1, done);
  endtask
  // Read data compared in the cycle after each read
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) begin
      chk("rdata", expq.pop_front(), rdata);
    end
  end
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    for (int m = 0; m < 8; m++) begin
      boot({m[2], 1'b0}, m[1:0]);
      wait_done(200);
      @(posedge clk);
      {act, vbus, preq} <= 6'($random(seed));
      settle;
      chk("nonrem", {1'b0, m[1:0] == 2'h3, m[1], m[1:0] != 2'h0}, nrem);
      chk("susp", act ^ m[0], susp);
      chk("selfp", !m[2], selfp);
      chk("ppen", preq, ppen);
      chk("pull", vbus, pull);
      chk("slave_en", 1'b0, sen);
    end
    boot(2'b01, 2'b11);
    vbus <= 1'b1;
    settle;
    chk("slave_en", 1'b1, sen);
    chk("slave_addr", 7'h2c, saddr);
    chk("pull", 1'b0, pull);
    chk("tt_per", 11'h5e8, tt.periodic);
    chk("tt_np", 9'h110, tt.nonper);
    chk("tt_bufs", 3'h4, tt.nonper_bufs);
    chk("sda_out", 1'b0, sda_o);
    d = 8'($random(seed)) & 8'h7f;
    reg_rd(8'hff, 8'h02);
    reg_rd(d, 8'h00);
    reg_wr(d, ~d);
    reg_rd(d, ~d);
    reg_wr(8'hd0, 8'h00);
    reg_wr(8'h09, 8'h06);
    reg_wr(8'h06, 8'h80);
    reg_rd(8'h09, 8'h06);
    reg_wr(8'hff, 8'h01);
    idle;
    wait_done(50);
    settle;
    chk("pull", 1'b1, pull);
    chk("nonrem", 4'h3, nrem);
    chk("selfp", 1'b1, selfp);
    chk("susp", act, susp);
    reg_rd(8'hff, 8'h03);
    idle;
    for (int p = 1; p >= 0; p--) begin
      present <= p[0];
      boot(2'b11, 2'b00);
      vbus <= 1'b1;
      settle;
      chk("pull", 1'b0, pull);
      wait_done(45000);
      settle;
      chk("pull", 1'b1, pull);
      chk("writes", p[0] ? 16'h3 : 16'h6, 16'(rx_bytes));
      e9 = p[0] ? 8'h35 : 8'hff;
      chk("nonrem", e9[4:1], nrem);
      chk("selfp", !p[0], selfp);
      for (int i = 0; i < 255; i++) begin
        reg_rd(8'(i), p[0] ? 8'(i) ^ 8'h3c : 8'hff);
      end
      reg_rd(8'hff, 8'h07);
      idle;
      vbus <= 1'b0;
      settle;
      chk("pull", 1'b0, pull);
    end
    print_verdict();
  end
endmodule

// [src/hcl_config_loader.sv]
// Hub start-up configuration loader: mode select, straps, EEPROM read, pull-up gate
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module hcl_config_loader #(
  parameter int QUARTER_CYC = hcl_pkg::I2C_QUARTER_CYC
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic config_select_lo_in,
  input wire logic config_select_hi_in,
  input wire logic nonremovable_strap_lo_in,
  input wire logic nonremovable_strap_hi_in,
  input wire logic upstream_vbus_detect_in,
  input wire logic hub_active_in,
  input wire logic [3:0] port_power_req_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic eeprom_scl_out,
  input wire logic eeprom_sda_in,
  output logic eeprom_sda_out,
  output logic eeprom_sda_oe_out,
  output logic smbus_slave_en_out,
  output logic [6:0] smbus_slave_addr_out,
  output logic config_done_out,
  output logic upstream_pullup_en_out,
  output logic suspend_indicator_out,
  output logic self_powered_out,
  output logic [3:0] nonremovable_ports_out,
  output logic [3:0] port_power_en_out,
  output hcl_pkg::hcl_tt_cfg_t tt_cfg_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int NPIN = 6;
  localparam int PIN_SDA = 0;
  localparam int PIN_VBUS = 1;
  localparam int PIN_STRAP_LO = 2;
  localparam int PIN_STRAP_HI = 3;
  localparam int PIN_SEL_LO = 4;
  localparam int PIN_SEL_HI = 5;
  localparam logic [7:0] START_MAX = 8'(hcl_pkg::STRAP_SETTLE_CYC);

  wire [NPIN-1:0] pins_raw = {config_select_hi_in, config_select_lo_in,
                              nonremovable_strap_hi_in, nonremovable_strap_lo_in,
                              upstream_vbus_detect_in, eeprom_sda_in};
  logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in) begin
        pin_s1_q[gi] <= pins_raw[gi];
        pin_s2_q[gi] <= pin_s1_q[gi];
        pin_s3_q[gi] <= pin_s2_q[gi];
      end
      always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
          pin_q[gi] <= 1'b0;
        end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Start-up latch of select and strap pins
  // ==========================================================================
  logic [7:0] start_cnt_q;
  logic latched_q;
  hcl_pkg::hcl_mode_t mode_q;
  logic [1:0] strap_q;
  wire latch_now = !latched_q && (start_cnt_q == START_MAX);

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      start_cnt_q <= 8'h00;
      latched_q <= 1'b0;
      mode_q <= hcl_pkg::HCL_MODE_SELF;
      strap_q <= 2'h0;
    end else if (!latched_q) begin
      start_cnt_q <= start_cnt_q + 8'h01;
      if (latch_now) begin
        latched_q <= 1'b1;
        mode_q <= hcl_pkg::hcl_mode_t'({pin_q[PIN_SEL_HI], pin_q[PIN_SEL_LO]});
        strap_q <= {pin_q[PIN_STRAP_HI], pin_q[PIN_STRAP_LO]};
      end
    end
  end

  wire mode_regs = (mode_q == hcl_pkg::HCL_MODE_SMBUS) || (mode_q == hcl_pkg::HCL_MODE_EEPROM);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [7:0] regs_q [256];
  logic [7:0] reg_rdata_q;
  logic config_done_q;
  hcl_pkg::hcl_state_t state_q;
  logic [7:0] ee_addr_q;
  logic [7:0] rx_shift_q;
  logic slot_end;
  logic [2:0] bit_cnt_q;
  wire ee_store = (state_q == hcl_pkg::HCL_ST_RX) && slot_end && (bit_cnt_q == 3'h0);
  wire host_wr = reg_wr_in && (reg_addr_in != hcl_pkg::REG_STATUS_CMD);
  wire [7:0] status_val = {5'h00, mode_q, config_done_q};

  // registers 0x00-0xfe read/write, 0xff is status/command; all reset to zero
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= hcl_pkg::REG_RESET_VAL;
      end
    end else if (ee_store) begin
      regs_q[ee_addr_q] <= rx_shift_q;
    end else if (host_wr) begin
      regs_q[reg_addr_in] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_q <= (reg_addr_in == hcl_pkg::REG_STATUS_CMD) ? status_val : regs_q[reg_addr_in];
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end
  assign reg_rdata_out = reg_rdata_q;

  // ==========================================================================
  // EEPROM read sequencer (two-wire master, read only)
  // ==========================================================================
  logic [15:0] qcnt_q;
  logic [1:0] quarter_q;
  logic [1:0] tx_idx_q;
  logic rd_phase_q;
  wire qtick = (qcnt_q == 16'(QUARTER_CYC - 1));
  assign slot_end = qtick && (quarter_q == hcl_pkg::QTR_LAST);
  wire sample_now = qtick && (quarter_q == hcl_pkg::QTR_SAMPLE);
  wire ee_last = (ee_addr_q == hcl_pkg::EE_LAST_ADDR);
  wire smbus_attach = (mode_q == hcl_pkg::HCL_MODE_SMBUS) && reg_wr_in &&
                      (reg_addr_in == hcl_pkg::REG_STATUS_CMD) &&
                      reg_wdata_in[hcl_pkg::STATUS_ATTACH_BIT];
  // write control byte, word address 0x00, then read control byte are sent
  wire [7:0] tx_byte = (tx_idx_q == hcl_pkg::TX_CTRL_WR) ? hcl_pkg::EE_CTRL_WRITE :
                       (tx_idx_q == hcl_pkg::TX_WORD_ADDR) ? hcl_pkg::EE_FIRST_ADDR :
                       hcl_pkg::EE_CTRL_READ;
  wire q_low = (quarter_q < 2'h2);
  wire q_mid = (quarter_q == 2'h1) || (quarter_q == 2'h2);
  logic sda_lvl, scl_lvl;

  always_comb begin
    sda_lvl = 1'b1;
    scl_lvl = 1'b1;
    case (state_q)
      hcl_pkg::HCL_ST_START: begin
        sda_lvl = q_low;
        scl_lvl = q_mid;
      end
      hcl_pkg::HCL_ST_TX: begin
        sda_lvl = tx_byte[bit_cnt_q];
        scl_lvl = q_mid;
      end
      hcl_pkg::HCL_ST_TACK, hcl_pkg::HCL_ST_RX: begin
        scl_lvl = q_mid;
      end
      hcl_pkg::HCL_ST_RACK: begin
        sda_lvl = ee_last;
        scl_lvl = q_mid;
      end
      hcl_pkg::HCL_ST_STOP: begin
        sda_lvl = !q_low;
        scl_lvl = (quarter_q != 2'h0);
      end
      default: begin
        sda_lvl = 1'b1;
        scl_lvl = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || state_q == hcl_pkg::HCL_ST_IDLE || qtick) begin
      qcnt_q <= 16'h0000;
    end else begin
      qcnt_q <= qcnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || state_q == hcl_pkg::HCL_ST_IDLE) begin
      quarter_q <= 2'h0;
    end else if (qtick) begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rx_shift_q <= 8'h00;
    end else if (sample_now && state_q == hcl_pkg::HCL_ST_RX) begin
      // whatever the bus returns is kept
      rx_shift_q <= {rx_shift_q[6:0], pin_q[PIN_SDA]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= hcl_pkg::HCL_ST_IDLE;
      bit_cnt_q <= hcl_pkg::BIT_MSB;
      tx_idx_q <= hcl_pkg::TX_CTRL_WR;
      ee_addr_q <= hcl_pkg::EE_FIRST_ADDR;
      rd_phase_q <= 1'b0;
      config_done_q <= 1'b0;
    end else begin
      case (state_q)
        hcl_pkg::HCL_ST_IDLE: begin
          if (latched_q) begin
            if (mode_q == hcl_pkg::HCL_MODE_EEPROM) begin
              state_q <= hcl_pkg::HCL_ST_START;
            end else if (mode_q == hcl_pkg::HCL_MODE_SMBUS) begin
              state_q <= hcl_pkg::HCL_ST_WAIT;
            end else begin
              state_q <= hcl_pkg::HCL_ST_DONE;
              config_done_q <= 1'b1;
            end
          end
        end
        hcl_pkg::HCL_ST_WAIT: begin
          // host download ends with attach command
          if (smbus_attach) begin
            state_q <= hcl_pkg::HCL_ST_DONE;
            config_done_q <= 1'b1;
          end
        end
        hcl_pkg::HCL_ST_START: begin
          if (slot_end) begin
            state_q <= hcl_pkg::HCL_ST_TX;
            bit_cnt_q <= hcl_pkg::BIT_MSB;
          end
        end
        hcl_pkg::HCL_ST_TX: begin
          if (slot_end) begin
            bit_cnt_q <= bit_cnt_q - 3'h1;
            if (bit_cnt_q == 3'h0) begin
              state_q <= hcl_pkg::HCL_ST_TACK;
            end
          end
        end
        hcl_pkg::HCL_ST_TACK: begin
          if (slot_end) begin
            bit_cnt_q <= hcl_pkg::BIT_MSB;
            if (tx_idx_q == hcl_pkg::TX_CTRL_WR) begin
              tx_idx_q <= hcl_pkg::TX_WORD_ADDR;
              state_q <= hcl_pkg::HCL_ST_TX;
            end else if (tx_idx_q == hcl_pkg::TX_WORD_ADDR) begin
              tx_idx_q <= hcl_pkg::TX_CTRL_RD;
              state_q <= hcl_pkg::HCL_ST_START;
            end else begin
              rd_phase_q <= 1'b1;
              state_q <= hcl_pkg::HCL_ST_RX;
            end
          end
        end
        hcl_pkg::HCL_ST_RX: begin
          if (slot_end) begin
            bit_cnt_q <= bit_cnt_q - 3'h1;
            if (bit_cnt_q == 3'h0) begin
              state_q <= hcl_pkg::HCL_ST_RACK;
            end
          end
        end
        hcl_pkg::HCL_ST_RACK: begin
          if (slot_end) begin
            bit_cnt_q <= hcl_pkg::BIT_MSB;
            if (ee_last) begin
              state_q <= hcl_pkg::HCL_ST_STOP;
            end else begin
              ee_addr_q <= ee_addr_q + 8'h01;
              state_q <= hcl_pkg::HCL_ST_RX;
            end
          end
        end
        hcl_pkg::HCL_ST_STOP: begin
          // done only after the last byte
          if (slot_end) begin
            state_q <= hcl_pkg::HCL_ST_DONE;
            config_done_q <= 1'b1;
          end
        end
        hcl_pkg::HCL_ST_DONE: begin
          state_q <= hcl_pkg::HCL_ST_DONE;
        end
        default: begin
          state_q <= hcl_pkg::HCL_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Settings selection
  // ==========================================================================
  // strap decode: count of fixed ports, polarity from low strap
  wire [3:0] strap_nonrem = 4'((5'h01 << strap_q) - 5'h01);
  wire strap_susp_low = strap_q[0];
  hcl_pkg::hcl_settings_t set_rom, set_regs, set_sel, set_q;
  assign set_rom = '{nonrem: strap_nonrem | hcl_pkg::ROM_NONREM[4:1],
                     susp_low: strap_susp_low,
                     self_pwr: (mode_q == hcl_pkg::HCL_MODE_SELF) &&
                               hcl_pkg::ROM_CFG_BYTE1[hcl_pkg::CFG1_SELF_PWR_BIT]};
  assign set_regs = '{nonrem: regs_q[hcl_pkg::REG_NONREM][4:1],
                      susp_low: 1'b0,
                      self_pwr: regs_q[hcl_pkg::REG_CFG_BYTE1][hcl_pkg::CFG1_SELF_PWR_BIT]};
  assign set_sel = mode_regs ? set_regs : set_rom;

  logic pullup_q, susp_q, slave_en_q;
  logic [3:0] pwr_q;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      set_q <= '0;
      pullup_q <= 1'b0;
      susp_q <= 1'b0;
      pwr_q <= 4'h0;
      slave_en_q <= 1'b0;
    end else begin
      set_q <= latched_q ? set_sel : '0;
      // pull-up needs VBUS and finished load
      pullup_q <= pin_q[PIN_VBUS] && config_done_q;
      susp_q <= latched_q && ((hub_active_in && config_done_q) ^ set_q.susp_low);
      pwr_q <= port_power_req_in;
      slave_en_q <= latched_q && (mode_q == hcl_pkg::HCL_MODE_SMBUS);
    end
  end

  assign eeprom_sda_out = 1'b0;
  assign eeprom_sda_oe_out = !sda_lvl;
  assign eeprom_scl_out = scl_lvl;
  assign smbus_slave_en_out = slave_en_q;
  assign smbus_slave_addr_out = hcl_pkg::SMBUS_SLAVE_ADDR;
  assign config_done_out = config_done_q;
  assign upstream_pullup_en_out = pullup_q;
  assign suspend_indicator_out = susp_q;
  assign self_powered_out = set_q.self_pwr;
  assign nonremovable_ports_out = set_q.nonrem;
  assign port_power_en_out = pwr_q;
  assign tt_cfg_out = '{periodic: hcl_pkg::TT_PERIODIC_BYTES,
                        nonper: hcl_pkg::TT_NONPER_BYTES,
                        nonper_bufs: hcl_pkg::TT_NONPER_BUFS};

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  AST_STRAP_DECODE: assert property (
    (latched_q && !mode_regs && strap_q == 2'h1) |=> ##1
      (nonremovable_ports_out == 4'h1) && self_powered_out == $past(set_rom.self_pwr, 2))
    else $error("strap 01 decode wrong");
  AST_STRAP_HI: assert property (
    (latched_q && !mode_regs && strap_q == 2'h3) |=> (nonremovable_ports_out == 4'h7))
    else $error("strap 11 decode wrong");
  AST_MODE_HELD: assert property (
    latched_q |=> $stable(mode_q) && $stable(strap_q))
    else $error("latched select changed");
  AST_SELF_PWR: assert property (
    (latched_q && mode_q == hcl_pkg::HCL_MODE_SELF) |=> self_powered_out)
    else $error("self-powered not set");
  AST_BUS_PWR: assert property (
    (latched_q && mode_q == hcl_pkg::HCL_MODE_BUS) |=> !self_powered_out)
    else $error("bus-powered not set");
  AST_REGS_WIN: assert property (
    (latched_q && mode_regs) |=> nonremovable_ports_out == $past(regs_q[hcl_pkg::REG_NONREM][4:1]))
    else $error("register settings not applied");
  AST_VBUS_OFF: assert property (
    !pin_q[PIN_VBUS] |=> !upstream_pullup_en_out)
    else $error("pull-up on without VBUS");
  AST_LOAD_HOLD: assert property (
    !config_done_q |=> !upstream_pullup_en_out)
    else $error("pull-up on during load");
  AST_READ_ONLY: assert property (
    (state_q == hcl_pkg::HCL_ST_RX) |-> rd_phase_q && eeprom_sda_oe_out == 1'b0)
    else $error("drive during read data");
  AST_ASCENDING: assert property (
    $changed(ee_addr_q) |-> ee_addr_q == $past(ee_addr_q) + 8'h01)
    else $error("address not ascending");
  AST_POWER_POL: assert property (
    $past(resetn_in) |-> port_power_en_out == $past(port_power_req_in))
    else $error("power enable polarity");

  COV_EEPROM_DONE: cover property (state_q == hcl_pkg::HCL_ST_STOP ##1 config_done_q);
  COV_SMBUS_ATTACH: cover property (state_q == hcl_pkg::HCL_ST_WAIT && smbus_attach);
  COV_DEFAULT_DONE: cover property (latched_q && !mode_regs && config_done_q);
  COV_VBUS_DROP: cover property (upstream_pullup_en_out ##1 !pin_q[PIN_VBUS]);

endmodule
